// File: rate_if.sv
// Link between the transfer engine and the serial clock divider
`timescale 1ns/1ps
interface rate_if;
	logic [1:0] rateSel;
	logic       run;
	logic       tick;

	modport divider (input rateSel, input run, output tick);
	modport engine (output rateSel, output run, input tick);
endinterface

// File: spi_master_slave_port.sv
// Serial peripheral port, master or slave, with APB register access
`timescale 1ns/1ps

module spi_master_slave_port (
	// System
	input  wire logic                                  mclk,
	input  wire logic                                  reset_n,
	// APB slave
	input  wire logic [spi_port_pkg::APB_ADDR_W-1:0]   paddr,
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [spi_port_pkg::APB_DATA_W-1:0]   pwdata,
	output logic      [spi_port_pkg::APB_DATA_W-1:0]   prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	// Serial clock pin
	input  wire logic                                  sclkIn,
	output logic                                       sclkOut,
	output logic                                       sclkOeN,
	// Master out, slave in pin
	input  wire logic                                  mosiIn,
	output logic                                       mosiOut,
	output logic                                       mosiOeN,
	// Master in, slave out pin
	input  wire logic                                  misoIn,
	output logic                                       misoOut,
	output logic                                       misoOeN,
	// Slave select pin, input only
	input  wire logic                                  ssIn,
	// Interrupt request
	output logic                                       portIrq
);
	import spi_port_pkg::*;

	typedef struct packed {
		logic [7:0]     control;
		logic [7:0]     shifter;
		logic [7:0]     rxBuf;
		logic [7:0]     rdData;
		logic [1:0]     intEnable;
		logic           doneFlag;
		logic           collFlag;
		xfer_state_type state;
		logic [3:0]     bitCount;
		logic           sampleBit;
		logic           sclkLevel;
		logic           sclkPrev;
	} port_state_type;

	port_state_type cur;
	port_state_type next;
	logic [1:0]     rstSync;
	logic           rstN;
	logic           enabled;
	logic           isMaster;
	logic           ignoreSs;
	logic           lsbFirst;
	logic           polarity;
	logic           phase;
	logic           busy;
	logic           selectedSlave;
	logic           modeChange;
	logic           masterToggle;
	logic           slaveChange;
	logic           leadEdge;
	logic           trailEdge;
	logic           sampleEdge;
	logic           shiftEdge;
	logic           inBit;
	logic           outBit;
	logic           finish;
	logic           wrAccess;
	logic           rdSetup;
	logic           mapped;
	logic           wrData;
	logic           startMaster;

	rate_if rateLink();

	spi_rate_divider divider (
		.mclk (mclk),
		.rstN (rstN),
		.rate (rateLink)
	);

	// Reset released through two flops so every flop leaves reset on the same edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	// Control field views
	assign enabled  = cur.control[CTL_ENABLE];
	assign isMaster = cur.control[CTL_ROLE];
	assign ignoreSs = cur.control[CTL_IGNORE_SS];
	assign lsbFirst = cur.control[CTL_ORDER];
	assign polarity = cur.control[CTL_POLARITY];
	assign phase    = cur.control[CTL_PHASE];
	assign busy     = cur.state != ST_IDLE;

	// Selection and mode change from the SS pin
	assign selectedSlave = enabled & !isMaster & (ignoreSs | !ssIn);
	assign modeChange    = enabled & isMaster & !ignoreSs & !ssIn;

	// Clock edges: generated locally as master, observed on the pin as slave
	assign masterToggle = rateLink.tick & (cur.state == ST_MASTER);
	assign slaveChange  = selectedSlave & (sclkIn != cur.sclkPrev);
	assign leadEdge  = masterToggle ? (cur.sclkLevel == polarity) : (slaveChange & (sclkIn != polarity));
	assign trailEdge = masterToggle ? (cur.sclkLevel != polarity) : (slaveChange & (sclkIn == polarity));
	assign sampleEdge = phase ? trailEdge : leadEdge;
	assign shiftEdge  = (phase ? leadEdge : trailEdge) & (cur.bitCount != 4'h0);

	// Data in from the far end, data out from the shifter end chosen by order
	assign inBit  = isMaster ? misoIn : mosiIn;
	assign outBit = lsbFirst ? cur.shifter[0] : cur.shifter[7];

	// APB decode; setup cycle captures read data so prdata comes from a flop
	assign wrAccess = psel & penable & pwrite;
	assign rdSetup  = psel & !penable & !pwrite;
	assign mapped   = (paddr == ADDR_CONTROL) | (paddr == ADDR_DATA) |
	                  (paddr == ADDR_STATUS) | (paddr == ADDR_INT_ENABLE);
	assign wrData   = wrAccess & (paddr == ADDR_DATA);
	assign startMaster = wrData & !busy & enabled & isMaster & !modeChange;

	// Shift one bit into the byte at the end that order selects
	function automatic logic [7:0] shift_in(input logic [7:0] value, input logic bitIn, input logic lsb);
		logic [7:0] result;
		result = lsb ? {bitIn, value[7:1]} : {value[6:0], bitIn};
		return result;
	endfunction

	// Next state of the whole port
	always_comb begin
		next = cur;
		finish = 1'b0;

		// Register writes first, so hardware sets below win over a write-one clear
		if (wrAccess) begin
			case (paddr)
				ADDR_CONTROL: begin
					next.control = pwdata[7:0];
				end
				ADDR_STATUS: begin
					if (pwdata[STAT_DONE]) begin
						next.doneFlag = 1'b0;
					end
					if (pwdata[STAT_COLL]) begin
						next.collFlag = 1'b0;
					end
				end
				ADDR_INT_ENABLE: begin
					next.intEnable = pwdata[1:0];
				end
				ADDR_DATA: begin
					if (!busy) begin
						next.shifter = pwdata[7:0];
					end
				end
				default: begin
					next.control = cur.control;
				end
			endcase
		end

		// A write on an idle enabled master launches one byte
		if (startMaster) begin
			next.state = ST_MASTER;
			next.bitCount = 4'h0;
		end

		// Slave becomes busy on the first leading edge while selected
		if (leadEdge && !masterToggle && cur.state == ST_IDLE) begin
			next.state = ST_SLAVE;
		end

		// Master clock toggles once per half bit; idle rests at the chosen level
		if (masterToggle) begin
			next.sclkLevel = !cur.sclkLevel;
		end else if (cur.state == ST_IDLE) begin
			next.sclkLevel = polarity;
		end
		next.sclkPrev = sclkIn;

		// Sampling edge latches the incoming bit; with phase set the last one ends the byte
		if (sampleEdge) begin
			next.sampleBit = inBit;
			next.bitCount = cur.bitCount + 4'h1;
			if (phase && cur.bitCount == BITS_PER_BYTE - 4'h1) begin
				next.shifter = shift_in(cur.shifter, inBit, lsbFirst);
				finish = 1'b1;
			end
		end

		// Shifting edge moves the latched bit in and presents the next outgoing bit
		if (shiftEdge) begin
			next.shifter = shift_in(cur.shifter, cur.sampleBit, lsbFirst);
			if (!phase && cur.bitCount == BITS_PER_BYTE) begin
				finish = 1'b1;
			end
		end

		// Completed byte goes to the read buffer, dropping any unread one
		if (finish) begin
			next.rxBuf = next.shifter;
			next.doneFlag = 1'b1;
			next.state = ST_IDLE;
			next.bitCount = 4'h0;
		end

		// Deselect or disable abandons a partial byte without raising done
		if ((cur.state == ST_SLAVE && !selectedSlave) || !enabled) begin
			next.state = ST_IDLE;
			next.bitCount = 4'h0;
		end

		// Another master pulls SS low: fall back to slave and report it
		if (modeChange) begin
			next.control[CTL_ROLE] = 1'b0;
			next.doneFlag = 1'b1;
			next.state = ST_IDLE;
			next.bitCount = 4'h0;
		end

		// Byte in flight keeps going; the colliding byte was never loaded
		if (wrData && busy) begin
			next.collFlag = 1'b1;
		end

		// Read data captured in the setup cycle; unmapped reads give zero
		if (rdSetup) begin
			case (paddr)
				ADDR_CONTROL:    next.rdData = cur.control;
				ADDR_DATA:       next.rdData = cur.rxBuf;
				ADDR_STATUS:     next.rdData = {cur.doneFlag, cur.collFlag, 6'h00};
				ADDR_INT_ENABLE: next.rdData = {6'h00, cur.intEnable};
				default:         next.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			cur <= '{control: CONTROL_RESET, shifter: DATA_RESET, rxBuf: DATA_RESET,
			         rdData: 8'h00, intEnable: INT_EN_RESET, doneFlag: 1'b0,
			         collFlag: 1'b0, state: ST_IDLE, bitCount: 4'h0,
			         sampleBit: 1'b0, sclkLevel: 1'b0, sclkPrev: 1'b0};
		end else begin
			cur <= next;
		end
	end

	// Divider runs only while the master shifts
	assign rateLink.rateSel = cur.control[CTL_RATE_HI:CTL_RATE_LO];
	assign rateLink.run     = cur.state == ST_MASTER;

	// Bus answers with no wait state; unmapped accesses flag an error
	assign prdata  = {24'h000000, cur.rdData};
	assign pready  = 1'b1;
	assign pslverr = psel & penable & !mapped;

	// Pin drivers: enables are low while driving, all released when disabled
	assign sclkOut = cur.sclkLevel;
	assign sclkOeN = !(enabled & isMaster);
	assign mosiOut = outBit;
	assign mosiOeN = !(enabled & isMaster);
	assign misoOut = outBit;
	assign misoOeN = !selectedSlave;

	// Interrupt needs both the port and the global enable
	assign portIrq = cur.doneFlag & cur.intEnable[INT_PORT] & cur.intEnable[INT_GLOBAL];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstN);

	// Fastest rate: one toggle, then one steady cycle, then the next toggle or stop
	sequence halfBitFast;
		$stable(sclkOut) ##1 ($changed(sclkOut) || cur.state != ST_MASTER);
	endsequence

	// Data write on idle master then clock starts within the slowest half period plus one cycle
	sequence masterLaunch;
		cur.state == ST_MASTER ##[1:65] $changed(sclkOut);
	endsequence

	pins_released_a: assert property (!enabled |-> sclkOeN && mosiOeN && misoOeN)
		else $error("pins driven while port disabled");

	clock_direction_a: assert property (enabled |-> (sclkOeN == !isMaster))
		else $error("serial clock direction does not follow role");

	slave_miso_a: assert property (enabled && !isMaster && ignoreSs |-> !misoOeN)
		else $error("slave ignoring select does not drive miso");

	idle_level_a: assert property (cur.state == ST_IDLE && $past(cur.state) == ST_IDLE && $stable(polarity)
		|-> sclkOut == polarity)
		else $error("idle clock not at chosen level");

	rate_fast_a: assert property (cur.state == ST_MASTER && rateLink.rateSel == 2'h0 && $changed(sclkOut)
		|=> halfBitFast)
		else $error("fastest serial clock half period wrong");

	master_start_a: assert property (startMaster |=> masterLaunch)
		else $error("data write did not start master clock");

	done_set_a: assert property (finish |=> cur.doneFlag && cur.rxBuf == $past(next.shifter))
		else $error("byte end did not set done or buffer");

	done_hold_a: assert property (cur.doneFlag && !(wrAccess && paddr == ADDR_STATUS && pwdata[STAT_DONE])
		|=> cur.doneFlag)
		else $error("done flag cleared without write of one");

	// A colliding write leaves the running byte going, unless it ends or aborts in that cycle
	collision_a: assert property (wrData && enabled && !finish && !modeChange && cur.state == ST_MASTER
		|=> cur.collFlag && cur.state == ST_MASTER)
		else $error("collision not flagged");

	coll_hold_a: assert property (cur.collFlag && !(wrAccess && paddr == ADDR_STATUS && pwdata[STAT_COLL])
		|=> cur.collFlag)
		else $error("collision flag cleared without write of one");

	mode_change_a: assert property (modeChange |=> !isMaster && cur.doneFlag && cur.state == ST_IDLE)
		else $error("select low on master did not change mode");

	irq_gate_a: assert property (portIrq |-> cur.doneFlag && cur.intEnable == 2'h3)
		else $error("interrupt raised without both enables");
endmodule

// File: spi_peer_model.sv
// Behavioural serial peripheral slave facing the port while it is master
`timescale 1ns/1ps
module spi_peer_model (
	// Serial lines
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       selN,
	output logic            miso,
	// Mode settings
	input  wire logic       clock_idle_level,
	input  wire logic       clock_phase_select,
	input  wire logic       lsbFirst,
	// Byte exchange
	input  wire logic [7:0] txByte,
	output logic [7:0]      rxByte
);
	logic [7:0] txShift;
	logic       started;
	logic       mosiLate;

	// Line delay stands for hold time: a bit changing with the last clock edge is not taken
	assign #1 mosiLate = mosi;

	// Bit on the line for the chosen order
	function automatic logic lineBit(input logic [7:0] v, input logic lsb);
		return lsb ? v[0] : v[7];
	endfunction

	// Quiet start
	initial begin
		miso    = 1'b0;
		rxByte  = 8'h00;
		txShift = 8'h00;
		started = 1'b0;
	end

	// Selection loads the byte; phase 0 shows its first bit at once
	always @(negedge selN) begin
		txShift = txByte;
		started = ~clock_phase_select;
		if (!clock_phase_select)
			miso = lineBit(txByte, lsbFirst);
	end

	// Released line flips so a stale bit never passes for a good one
	always @(posedge selN)
		miso = ~miso;

	// Sample edge is leading in phase 0, trailing in phase 1
	always @(sclk) begin
		if (!selN) begin
			if (((sclk !== clock_idle_level) ^ clock_phase_select) == 1'b1) begin
				rxByte = lsbFirst ? {mosiLate, rxByte[7:1]} : {rxByte[6:0], mosiLate};
			end else begin
				if (started)
					txShift = lsbFirst ? (txShift >> 1) : (txShift << 1);
				started = 1'b1;
				miso    = lineBit(txShift, lsbFirst);
			end
		end
	end
endmodule

// File: spi_port_pkg.sv
// Shared constants and types of the serial peripheral port
package spi_port_pkg;

	// Bus geometry
	localparam int APB_ADDR_W = 8;
	localparam int APB_DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] ADDR_CONTROL    = 8'h00;
	localparam logic [7:0] ADDR_DATA       = 8'h04;
	localparam logic [7:0] ADDR_STATUS     = 8'h08;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'h0c;

	// Control register fields
	localparam int CTL_IGNORE_SS = 7;
	localparam int CTL_ENABLE    = 6;
	localparam int CTL_ORDER     = 5;
	localparam int CTL_ROLE      = 4;
	localparam int CTL_POLARITY  = 3;
	localparam int CTL_PHASE     = 2;
	localparam int CTL_RATE_HI   = 1;
	localparam int CTL_RATE_LO   = 0;

	// Status and interrupt enable fields
	localparam int STAT_DONE  = 7;
	localparam int STAT_COLL  = 6;
	localparam int INT_PORT   = 0;
	localparam int INT_GLOBAL = 1;

	// Values after reset
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET    = 8'h00;
	localparam logic [1:0] INT_EN_RESET  = 2'h0;

	// Serial clock dividers and their half periods
	localparam int RATE_DIV_0 = 4;
	localparam int RATE_DIV_1 = 16;
	localparam int RATE_DIV_2 = 64;
	localparam int RATE_DIV_3 = 128;
	localparam int HALF_W     = 7;
	localparam logic [HALF_W-1:0] HALF_RATE_0 = HALF_W'(RATE_DIV_0 / 2);
	localparam logic [HALF_W-1:0] HALF_RATE_1 = HALF_W'(RATE_DIV_1 / 2);
	localparam logic [HALF_W-1:0] HALF_RATE_2 = HALF_W'(RATE_DIV_2 / 2);
	localparam logic [HALF_W-1:0] HALF_RATE_3 = HALF_W'(RATE_DIV_3 / 2);

	// Throughput target and the core clock
	localparam int CLK_HZ          = 25000000;
	localparam int MAX_RATE_BPS    = 3000000;
	localparam int MAX_RATE_CYCLES = CLK_HZ / MAX_RATE_BPS;

	// Byte length
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Transfer engine states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_MASTER = 2'b01,
		ST_SLAVE  = 2'b10
	} xfer_state_type;

endpackage

// File: spi_rate_divider.sv
// Half-bit enable pulse generator for the master serial clock
`timescale 1ns/1ps
module spi_rate_divider (
	// System
	input  wire logic mclk,
	input  wire logic rstN,
	// Engine side
	rate_if.divider   rate
);
	import spi_port_pkg::*;

	typedef struct packed {
		logic [HALF_W-1:0] count;
		logic              tick;
	} div_state_type;

	div_state_type            cur;
	div_state_type            next;
	logic          [HALF_W-1:0] halfCount;

	// Half period per rate field value
	always_comb begin
		case (rate.rateSel)
			2'h0:    halfCount = HALF_RATE_0;
			2'h1:    halfCount = HALF_RATE_1;
			2'h2:    halfCount = HALF_RATE_2;
			2'h3:    halfCount = HALF_RATE_3;
			default: halfCount = HALF_RATE_0;
		endcase
	end

	// Counter restarts whenever the engine stops, so each byte begins on a full half bit
	always_comb begin
		next = cur;
		next.tick = 1'b0;
		if (!rate.run) begin
			next.count = '0;
		end else if (cur.count == halfCount - HALF_W'(1)) begin
			next.count = '0;
			next.tick = 1'b1;
		end else begin
			next.count = cur.count + HALF_W'(1);
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			cur <= '0;
		end else begin
			cur <= next;
		end
	end

	assign rate.tick = cur.tick & rate.run;
endmodule

// File: testbench.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module testbench;
	import spi_port_pkg::*;
	// Clock, reset and bus
	logic                  mclk;
	logic                  reset_n;
	logic [APB_ADDR_W-1:0] paddr;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [APB_DATA_W-1:0] pwdata;
	logic [APB_DATA_W-1:0] prdata;
	logic                  pready;
	logic                  pslverr;
	// Pins and their resolved wires
	logic                  sclkIn;
	logic                  sclkOut;
	logic                  sclkOeN;
	logic                  mosiIn;
	logic                  mosiOut;
	logic                  mosiOeN;
	logic                  misoIn;
	logic                  misoOut;
	logic                  misoOeN;
	logic                  ssIn;
	logic                  portIrq;
	// Far side drive
	logic                  tbSclk;
	logic                  tbMosi;
	logic                  peerSelN;
	logic                  peerMiso;
	logic                  peerCpol;
	logic                  peerCpha;
	logic                  peerLsb;
	logic [7:0]            peerTx;
	logic [7:0]            peerRx;
	int                    err_total;
	int                    compares;
	int                    divs [4] = '{RATE_DIV_0, RATE_DIV_1, RATE_DIV_2, RATE_DIV_3};

	// Wire levels from whichever party is driving
	assign sclkIn = sclkOeN ? tbSclk : sclkOut;
	assign mosiIn = mosiOeN ? tbMosi : mosiOut;
	assign misoIn = misoOeN ? peerMiso : misoOut;

	spi_master_slave_port u_spi_master_slave_port (
		.mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOeN(sclkOeN), .mosiIn(mosiIn), .mosiOut(mosiOut),
		.mosiOeN(mosiOeN), .misoIn(misoIn), .misoOut(misoOut), .misoOeN(misoOeN), .ssIn(ssIn),
		.portIrq(portIrq));

	spi_peer_model u_spi_peer_model (
		.sclk(sclkIn), .mosi(mosiIn), .selN(peerSelN), .miso(peerMiso), .clock_idle_level(peerCpol),
		.clock_phase_select(peerCpha), .lsbFirst(peerLsb), .txByte(peerTx), .rxByte(peerRx));

	// Core clock, 40 ns
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A wait that used up its bound counts as a mismatch and ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			err_total++;
			tally_and_finish();
		end
	endtask

	// One APB transfer; request held until pready is seen
	task automatic apbXfer(input logic [7:0] a, input logic wr, input logic [7:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= wr;
		pwdata  <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		bound(n, 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        e;
		apbXfer(a, 1'b1, d, rd, e);
	endtask

	task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] rd;
		logic        e;
		apbXfer(a, 1'b0, 8'h00, rd, e);
		check(rd, {24'h000000, exp});
	endtask

	// Poll the done flag; a hang counts as a mismatch
	task automatic waitDone();
		logic [31:0] rd;
		logic        e;
		int          n;
		n = 0;
		do begin
			apbXfer(ADDR_STATUS, 1'b0, 8'h00, rd, e);
			n++;
		end while (rd[STAT_DONE] !== 1'b1 && n < 400);
		bound(n, 400);
	endtask

	// Plays master in mode 0, MSB first, half period of 4 core cycles
	task automatic slaveByte(input logic [7:0] tx, input logic [7:0] expMiso);
		logic [7:0] got;
		for (int b = 7; b >= 0; b--) begin
			tbMosi <= tx[b];
			repeat (4) @(posedge mclk);
			got[b] = misoIn;
			tbSclk <= 1'b1;
			repeat (4) @(posedge mclk);
			tbSclk <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		check(32'(got), 32'(expMiso));
	endtask

	task automatic settle();
		repeat (2) @(negedge mclk);
	endtask

	// Main sequence
	initial begin
		logic [31:0] rd;
		logic        e;
		logic        lvl;
		int          n;
		err_total = 0;
		compares  = 0;
		reset_n   = 1'b0;
		paddr     = '0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		pwdata    = '0;
		ssIn      = 1'b1;
		tbSclk    = 1'b0;
		tbMosi    = 1'b0;
		peerSelN  = 1'b1;
		peerCpol  = 1'b0;
		peerCpha  = 1'b0;
		peerLsb   = 1'b0;
		peerTx    = 8'h00;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		check(32'({sclkOeN, mosiOeN, misoOeN}), 32'h7);
		rdck(ADDR_CONTROL, CONTROL_RESET);
		rdck(ADDR_DATA, DATA_RESET);
		rdck(ADDR_STATUS, 8'h00);
		rdck(ADDR_INT_ENABLE, 8'h00);
		apbXfer(8'h10, 1'b0, 8'h00, rd, e);
		check(rd, 32'h0);
		check(32'(e), 32'h1);
		// Every mode, both orders, every rate, as master
		for (int i = 0; i < 8; i++) begin
			peerCpol <= i[1];
			peerCpha <= i[0];
			peerLsb  <= i[2];
			peerTx   <= 8'h5a ^ 8'(i);
			wr(ADDR_CONTROL, {2'b11, i[2], 1'b1, i[1], i[0], i[1:0]});
			// Clock reaches its new idle level before the peer listens, so no false edge
			settle();
			peerSelN <= 1'b0;
			check(32'({sclkOeN, mosiOeN, misoOeN}), 32'h1);
			wr(ADDR_DATA, 8'hc3 + 8'(i));
			n = 0;
			while (sclkOut === i[1] && n < 300) begin
				@(negedge mclk);
				n++;
			end
			bound(n, 300);
			lvl = sclkOut;
			n = 0;
			while (sclkOut === lvl && n < 300) begin
				@(negedge mclk);
				n++;
			end
			bound(n, 300);
			check(32'(n), 32'(divs[i % 4] / 2));
			waitDone();
			peerSelN <= 1'b1;
			check(32'(sclkOut), 32'(i[1]));
			check(32'(peerRx), 32'(8'hc3 + 8'(i)));
			rdck(ADDR_DATA, 8'h5a ^ 8'(i));
			wr(ADDR_STATUS, 8'h00);
			rdck(ADDR_STATUS, 8'h80);
			wr(ADDR_STATUS, 8'h80);
			rdck(ADDR_STATUS, 8'h00);
		end
		// Second write while shifting collides and is dropped
		peerCpol <= 1'b0;
		peerCpha <= 1'b0;
		peerLsb  <= 1'b0;
		wr(ADDR_CONTROL, 8'hd1);
		settle();
		peerSelN <= 1'b0;
		wr(ADDR_DATA, 8'h81);
		wr(ADDR_DATA, 8'h7e);
		rdck(ADDR_STATUS, 8'h40);
		waitDone();
		peerSelN <= 1'b1;
		check(32'(peerRx), 32'h81);
		wr(ADDR_STATUS, 8'h40);
		rdck(ADDR_STATUS, 8'h80);
		// Interrupt needs both enables
		wr(ADDR_INT_ENABLE, 8'h01);
		settle();
		check(32'(portIrq), 32'h0);
		wr(ADDR_INT_ENABLE, 8'h03);
		settle();
		check(32'(portIrq), 32'h1);
		wr(ADDR_STATUS, 8'h80);
		settle();
		check(32'(portIrq), 32'h0);
		wr(ADDR_INT_ENABLE, 8'h00);
		// Idle master pulled low by another master
		wr(ADDR_CONTROL, 8'h50);
		ssIn <= 1'b0;
		repeat (4) @(posedge mclk);
		rdck(ADDR_CONTROL, 8'h40);
		rdck(ADDR_STATUS, 8'h80);
		check(32'({sclkOeN, misoOeN}), 32'h2);
		wr(ADDR_STATUS, 8'h80);
		// Selected slave, then two unread bytes
		wr(ADDR_DATA, 8'h3c);
		slaveByte(8'h96, 8'h3c);
		rdck(ADDR_DATA, 8'h96);
		rdck(ADDR_STATUS, 8'h80);
		slaveByte(8'h21, 8'h96);
		slaveByte(8'h44, 8'h21);
		rdck(ADDR_DATA, 8'h44);
		// Select pin honoured or ignored
		ssIn <= 1'b1;
		settle();
		check(32'(misoOeN), 32'h1);
		wr(ADDR_CONTROL, 8'hc0);
		settle();
		check(32'(misoOeN), 32'h0);
		wr(ADDR_CONTROL, 8'h00);
		settle();
		check(32'({sclkOeN, mosiOeN, misoOeN}), 32'h7);
		tally_and_finish();
	end
endmodule
